// ### common/tcc_pkg.sv
package tcc_pkg;

  // widths
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int NCH = 2;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CH0_CTRL = 6'h16;
  localparam logic [IDX_W-1:0] IDX_CH0_HI = 6'h17;
  localparam logic [IDX_W-1:0] IDX_CH0_LO = 6'h18;
  localparam logic [IDX_W-1:0] IDX_CH1_CTRL = 6'h19;
  localparam logic [IDX_W-1:0] IDX_CH1_HI = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_CH1_LO = 6'h1b;

  // control register bit positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_MSB = 5;
  localparam int BIT_MSA = 4;
  localparam int BIT_ELS_HI = 3;
  localparam int BIT_ELS_LO = 2;
  localparam int BIT_TOV = 1;
  localparam int BIT_MAX = 0;

  // edge/level codes
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
  localparam logic [1:0] ELS_BOTH_SET = 2'h3;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;

  typedef enum logic [3:0] {
    TCC_MD_OFF = 4'b0001,
    TCC_MD_CAP = 4'b0010,
    TCC_MD_OC = 4'b0100,
    TCC_MD_BUF = 4'b1000
  } tcc_mode_t;

  // control state, cleared by reset
  typedef struct packed {
    logic [NCH-1:0] flag;
    logic [NCH-1:0] ie;
    logic msb;
    logic [NCH-1:0] msa;
    logic [NCH-1:0][1:0] els;
    logic [NCH-1:0] tov;
    logic [NCH-1:0] maxf;
    logic [NCH-1:0] max_eff;
    logic [NCH-1:0] arm;
    logic [NCH-1:0] cap_inh;
    logic [NCH-1:0] cmp_inh;
    logic [NCH-1:0] pin_prev;
    logic [NCH-1:0] out;
    logic [CNT_W-1:0] count;
    logic cnt_upd;
    logic ovf;
    logic buf_sel;
    logic buf_pend;
    logic [BYTE_W-1:0] prdata;
  } tcc_ctl_t;

  // channel value registers, left alone by reset
  typedef struct packed {
    logic [NCH-1:0][BYTE_W-1:0] hi;
    logic [NCH-1:0][BYTE_W-1:0] lo;
  } tcc_dat_t;

  typedef struct packed {
    tcc_ctl_t c;
    tcc_dat_t d;
  } tcc_st_t;

  localparam tcc_ctl_t TCC_CTL_RESET = '0;

endpackage

// ### src/tcc_channels.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - capture mode: selected active pin edge sets the channel event flag
// - compare mode: counter equal to channel registers sets the event flag
// - flag clears on read-with-flag-set then write zero; new event cancels
// - writing one to the flag does nothing; reset clears the flag
// - interrupt request while enable and flag both set; reset clears enable
// - buffered select only in channel 0; it disables channel 1 and frees pin
// - nonzero edge/level, unbuffered: mode bit picks compare/PWM or capture
// - edge/level 00: mode bit presets output, one low, zero high
// - edge/level 00 disconnects the channel from its pin
// - capture edge: 01 rising, 10 falling, 11 either
// - compare action: 01 toggle, 10 drive low, 11 drive high
// - compare mode with toggle-on-overflow toggles pin each overflow
// - toggle-on-overflow: overflow action beats a same-cycle compare
// - full duty bit forces 100% PWM only while toggle-on-overflow is clear, applied from next period
// - channel registers take counter on capture, hold compare value
// - capture mode: high byte read blocks captures until low byte read
// - compare modes: high byte write blocks matches until low byte write
// - channel registers are not initialised by reset
// - reset clears mode select and edge/level bits, pins to port control
// - halt stops counter, clear zeroes it, both hold it at zero
// - overflow when counter at modulo restarts from zero next tick
module tcc_channels
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [tcc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // shared counter
  input wire logic COUNT_TICK,
  input wire logic COUNTER_HALT,
  input wire logic COUNTER_CLEAR,
  input wire logic [tcc_pkg::CNT_W-1:0] MODULO_VALUE,
  output logic [tcc_pkg::CNT_W-1:0] COUNT_VALUE,
  output logic OVERFLOW,
  // channel pins
  input wire logic [tcc_pkg::NCH-1:0] CHAN_PIN_IN,
  output logic [tcc_pkg::NCH-1:0] CHAN_PIN_OUT,
  output logic [tcc_pkg::NCH-1:0] CHAN_PIN_OE,
  // interrupt requests
  output logic [tcc_pkg::NCH-1:0] CHAN_IRQ
);
  import tcc_pkg::*;

  tcc_st_t st_reg;
  tcc_st_t st_next;

  logic [IDX_W-1:0] idx;
  logic access;
  logic wr;
  logic rd;

  function automatic tcc_mode_t chan_mode(input logic msb, input logic msa,
                                          input logic [1:0] els);
    if (els == ELS_OFF)
    begin
      return TCC_MD_OFF;
    end
    else if (msb)
    begin
      return TCC_MD_BUF;
    end
    else if (msa)
    begin
      return TCC_MD_OC;
    end
    else
    begin
      return TCC_MD_CAP;
    end
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] ix;
    ix = addr[ADDR_W-1:IDX_LSB];
    return (addr[IDX_LSB-1:0] == ADDR_ALIGN) &&
           (ix == IDX_CH0_CTRL || ix == IDX_CH0_HI || ix == IDX_CH0_LO ||
            ix == IDX_CH1_CTRL || ix == IDX_CH1_HI || ix == IDX_CH1_LO);
  endfunction

  function automatic logic [BYTE_W-1:0] ctrl_byte(input tcc_ctl_t c, input int ch);
    logic [BYTE_W-1:0] b;
    b = BYTE_ZERO;
    b[BIT_FLAG] = c.flag[ch];
    b[BIT_IE] = c.ie[ch];
    b[BIT_MSB] = (ch == 0) ? c.msb : 1'b0;
    b[BIT_MSA] = c.msa[ch];
    b[BIT_ELS_HI] = c.els[ch][1];
    b[BIT_ELS_LO] = c.els[ch][0];
    b[BIT_TOV] = c.tov[ch];
    b[BIT_MAX] = c.maxf[ch];
    return b;
  endfunction

  function automatic logic [IDX_W-1:0] ctrl_idx(input int ch);
    return (ch == 0) ? IDX_CH0_CTRL : IDX_CH1_CTRL;
  endfunction

  function automatic logic [IDX_W-1:0] hi_idx(input int ch);
    return (ch == 0) ? IDX_CH0_HI : IDX_CH1_HI;
  endfunction

  function automatic logic [IDX_W-1:0] lo_idx(input int ch);
    return (ch == 0) ? IDX_CH0_LO : IDX_CH1_LO;
  endfunction

  assign idx = PADDR[ADDR_W-1:IDX_LSB];
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE & is_mapped(PADDR);
  assign rd = access & ~PWRITE & is_mapped(PADDR);

  always_comb
  begin
    tcc_mode_t mode;
    logic [CNT_W-1:0] cmpv;
    logic rise;
    logic fall;
    logic edge_hit;
    logic cap_ev;
    logic match;
    logic inh;
    logic ev;
    logic [BYTE_W-1:0] wb;
    mode = TCC_MD_OFF;
    cmpv = CNT_ZERO;
    rise = 1'b0;
    fall = 1'b0;
    edge_hit = 1'b0;
    cap_ev = 1'b0;
    match = 1'b0;
    inh = 1'b0;
    ev = 1'b0;
    wb = PWDATA[BYTE_W-1:0];
    st_next = st_reg;

    // shared counter
    st_next.c.cnt_upd = 1'b0;
    st_next.c.ovf = 1'b0;
    if (COUNTER_CLEAR)
    begin
      st_next.c.count = CNT_ZERO;
    end
    else if (!COUNTER_HALT && COUNT_TICK)
    begin
      st_next.c.cnt_upd = 1'b1;
      if (st_reg.c.count == MODULO_VALUE)
      begin
        st_next.c.count = CNT_ZERO;
        st_next.c.ovf = 1'b1;
      end
      else
      begin
        st_next.c.count = st_reg.c.count + CNT_ONE;
      end
    end

    // read data captured in the setup phase
    if (PSEL && !PENABLE && !PWRITE)
    begin
      case (idx)
        IDX_CH0_CTRL: st_next.c.prdata = ctrl_byte(st_reg.c, 0);
        IDX_CH1_CTRL: st_next.c.prdata = ctrl_byte(st_reg.c, 1);
        IDX_CH0_HI: st_next.c.prdata = st_reg.d.hi[0];
        IDX_CH0_LO: st_next.c.prdata = st_reg.d.lo[0];
        IDX_CH1_HI: st_next.c.prdata = st_reg.d.hi[1];
        IDX_CH1_LO: st_next.c.prdata = st_reg.d.lo[1];
        default: st_next.c.prdata = BYTE_ZERO;
      endcase
      if (!is_mapped(PADDR))
      begin
        st_next.c.prdata = BYTE_ZERO;
      end
    end

    // buffered register alternation
    if (chan_mode(st_reg.c.msb, st_reg.c.msa[0], st_reg.c.els[0]) != TCC_MD_BUF)
    begin
      st_next.c.buf_sel = 1'b0;
      st_next.c.buf_pend = 1'b0;
    end
    else
    begin
      if (st_reg.c.ovf && st_reg.c.buf_pend)
      begin
        st_next.c.buf_sel = ~st_reg.c.buf_sel;
        st_next.c.buf_pend = 1'b0;
      end
      if (wr && idx == lo_idx(st_reg.c.buf_sel ? 0 : 1))
      begin
        st_next.c.buf_pend = 1'b1;
      end
    end

    for (int i = 0; i < NCH; i++)
    begin
      if (i == 1 && st_reg.c.msb)
      begin
        mode = TCC_MD_OFF;
      end
      else
      begin
        mode = chan_mode((i == 0) ? st_reg.c.msb : 1'b0, st_reg.c.msa[i],
                         st_reg.c.els[i]);
      end

      // compare source and its inhibit
      if (mode == TCC_MD_BUF && st_reg.c.buf_sel)
      begin
        cmpv = {st_reg.d.hi[1], st_reg.d.lo[1]};
        inh = st_reg.c.cmp_inh[1];
      end
      else
      begin
        cmpv = {st_reg.d.hi[i], st_reg.d.lo[i]};
        inh = st_reg.c.cmp_inh[i];
      end

      // edge detection
      rise = CHAN_PIN_IN[i] & ~st_reg.c.pin_prev[i];
      fall = ~CHAN_PIN_IN[i] & st_reg.c.pin_prev[i];
      case (st_reg.c.els[i])
        ELS_RISE_TOGGLE: edge_hit = rise;
        ELS_FALL_CLEAR: edge_hit = fall;
        ELS_BOTH_SET: edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
      st_next.c.pin_prev[i] = CHAN_PIN_IN[i];

      cap_ev = (mode == TCC_MD_CAP) && edge_hit && !st_reg.c.cap_inh[i];
      match = (mode == TCC_MD_OC || mode == TCC_MD_BUF) && st_reg.c.cnt_upd &&
              (st_reg.c.count == cmpv) && !inh;
      ev = cap_ev | match;

      // pin level
      if (mode == TCC_MD_OFF)
      begin
        st_next.c.out[i] = ~st_reg.c.msa[i];
      end
      else if (mode == TCC_MD_OC || mode == TCC_MD_BUF)
      begin
        if (st_reg.c.ovf)
        begin
          st_next.c.max_eff[i] = st_reg.c.maxf[i];
        end
        if (st_reg.c.ovf && st_reg.c.tov[i])
        begin
          st_next.c.out[i] = ~st_reg.c.out[i];
        end
        else if (st_reg.c.max_eff[i] && !st_reg.c.tov[i])
        begin
          case (st_reg.c.els[i])
            ELS_FALL_CLEAR: st_next.c.out[i] = 1'b1;
            ELS_BOTH_SET: st_next.c.out[i] = 1'b0;
            default: st_next.c.out[i] = st_reg.c.out[i];
          endcase
        end
        else if (match)
        begin
          case (st_reg.c.els[i])
            ELS_RISE_TOGGLE: st_next.c.out[i] = ~st_reg.c.out[i];
            ELS_FALL_CLEAR: st_next.c.out[i] = 1'b0;
            ELS_BOTH_SET: st_next.c.out[i] = 1'b1;
            default: st_next.c.out[i] = st_reg.c.out[i];
          endcase
        end
      end

      // control register write
      if (wr && idx == ctrl_idx(i) && !(i == 1 && st_reg.c.msb))
      begin
        st_next.c.ie[i] = wb[BIT_IE];
        st_next.c.msa[i] = wb[BIT_MSA];
        st_next.c.els[i] = {wb[BIT_ELS_HI], wb[BIT_ELS_LO]};
        st_next.c.tov[i] = wb[BIT_TOV];
        st_next.c.maxf[i] = wb[BIT_MAX];
        if (i == 0)
        begin
          st_next.c.msb = wb[BIT_MSB];
        end
        if (!wb[BIT_FLAG] && st_reg.c.arm[i])
        begin
          st_next.c.flag[i] = 1'b0;
        end
      end

      // two-step clear arming
      if (ev)
      begin
        st_next.c.arm[i] = 1'b0;
        st_next.c.flag[i] = 1'b1;
      end
      else if (rd && idx == ctrl_idx(i) && st_reg.c.flag[i])
      begin
        st_next.c.arm[i] = 1'b1;
      end
      else if (wr && idx == ctrl_idx(i))
      begin
        st_next.c.arm[i] = 1'b0;
      end

      // channel value registers
      if (wr && idx == hi_idx(i))
      begin
        st_next.d.hi[i] = wb;
        st_next.c.cmp_inh[i] = (mode != TCC_MD_CAP);
      end
      if (wr && idx == lo_idx(i))
      begin
        st_next.d.lo[i] = wb;
        st_next.c.cmp_inh[i] = 1'b0;
      end
      if (rd && idx == hi_idx(i) && mode == TCC_MD_CAP)
      begin
        st_next.c.cap_inh[i] = 1'b1;
      end
      if (rd && idx == lo_idx(i))
      begin
        st_next.c.cap_inh[i] = 1'b0;
      end
      if (cap_ev)
      begin
        {st_next.d.hi[i], st_next.d.lo[i]} = st_reg.c.count;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_reg.c <= TCC_CTL_RESET;
    end
    else if (CE)
    begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign PRDATA = {24'h000000, st_reg.c.prdata};
  assign PREADY = CE;
  assign PSLVERR = access & CE & ~is_mapped(PADDR);
  assign COUNT_VALUE = st_reg.c.count;
  assign OVERFLOW = st_reg.c.ovf;
  assign CHAN_PIN_OUT = st_reg.c.out;
  assign CHAN_IRQ = st_reg.c.flag & st_reg.c.ie;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      CHAN_PIN_OE[i] = (st_reg.c.els[i] != ELS_OFF) && !(i == 1 && st_reg.c.msb) &&
                       (st_reg.c.msa[i] || (i == 0 && st_reg.c.msb));
    end
  end

endmodule

// ### dv/tcc_properties.sv
`timescale 1ns/1ps
module tcc_props
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  // bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  // counter
  input wire logic COUNT_TICK,
  input wire logic COUNTER_HALT,
  input wire logic COUNTER_CLEAR,
  input wire logic [tcc_pkg::CNT_W-1:0] MODULO_VALUE,
  input wire logic [tcc_pkg::CNT_W-1:0] COUNT_VALUE,
  input wire logic OVERFLOW,
  // pins and requests
  input wire logic [tcc_pkg::NCH-1:0] CHAN_PIN_OE,
  input wire logic [tcc_pkg::NCH-1:0] CHAN_IRQ
);
  import tcc_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic run;
  logic wr;
  assign run = CE && COUNT_TICK && !COUNTER_HALT && !COUNTER_CLEAR;
  assign wr = PSEL && PENABLE && PWRITE && CE;
  property p_clr; CE && COUNTER_CLEAR |=> COUNT_VALUE == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("counter not cleared");
  property p_halt; CE && COUNTER_HALT && !COUNTER_CLEAR |=> $stable(COUNT_VALUE); endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");
  property p_adv;
    run && COUNT_VALUE != MODULO_VALUE |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001;
  endproperty
  a_adv: assert property (p_adv) else $error("counter did not advance");
  property p_wrap;
    run && COUNT_VALUE == MODULO_VALUE |=> OVERFLOW && COUNT_VALUE == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at modulo");
  property p_ovz; OVERFLOW |-> COUNT_VALUE == 16'h0000; endproperty
  a_ovz: assert property (p_ovz) else $error("overflow with nonzero count");
  property p_ovc;
    OVERFLOW && $past(CE) |-> $past(COUNT_TICK) && $past(COUNT_VALUE) == $past(MODULO_VALUE);
  endproperty
  a_ovc: assert property (p_ovc) else $error("overflow without modulo");
  property p_rst; $fell(RST) |-> CHAN_PIN_OE == 2'b00 && CHAN_IRQ == 2'b00; endproperty
  a_rst: assert property (p_rst) else $error("pins or requests active");
  property p_irqf; |($past(CHAN_IRQ) & ~CHAN_IRQ) |-> $past(wr); endproperty
  a_irqf: assert property (p_irqf) else $error("request dropped without write");
  c_ovf: cover property (OVERFLOW);
  c_irq: cover property ($rose(CHAN_IRQ[0]));
  c_oe: cover property ($rose(CHAN_PIN_OE[1]));
endmodule
bind tcc_channels tcc_props tcc_props_i (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .COUNT_TICK(COUNT_TICK),
  .COUNTER_HALT(COUNTER_HALT), .COUNTER_CLEAR(COUNTER_CLEAR),
  .MODULO_VALUE(MODULO_VALUE), .COUNT_VALUE(COUNT_VALUE), .OVERFLOW(OVERFLOW),
  .CHAN_PIN_OE(CHAN_PIN_OE), .CHAN_IRQ(CHAN_IRQ));

// ### dv/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model
(
  // clock
  input wire logic clk,
  // levels
  input wire logic [1:0] lvl,
  input wire logic [1:0] oe,
  input wire logic [1:0] out,
  output logic [1:0] pin
);
  initial pin = 2'b00;
  // pin reads back the timer level while driven
  always @(posedge clk)
  begin
    pin <= (oe & out) | (~oe & lvl);
  end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CK(n, x, y) begin tests_run++; if ((y) !== (x)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, x, y); end end
module tb_top;
  import tcc_pkg::*;
  logic SYS_CLK = 0;
  logic RST = 1;
  logic CE = 1;
  logic PSEL = 0;
  logic PENABLE = 0;
  logic PWRITE = 0;
  logic COUNT_TICK = 1;
  logic COUNTER_HALT = 1;
  logic COUNTER_CLEAR = 1;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, OVERFLOW;
  logic [15:0] MODULO_VALUE = 16'h00ff;
  logic [15:0] COUNT_VALUE;
  logic [1:0] CHAN_PIN_IN, CHAN_PIN_OUT, CHAN_PIN_OE, CHAN_IRQ;
  logic [1:0] lvl = 0;
  int fail_count = 0;
  int tests_run = 0;
  int m = 0;
  int k;
  bit o = 0;
  logic [31:0] s = 32'hfbc16650;
  logic [7:0] q, c, h;
  logic [15:0] r;
  logic e, p;
  always #10 SYS_CLK = ~SYS_CLK;
  tcc_channels tcc_channels_i (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .COUNT_TICK(COUNT_TICK),
    .COUNTER_HALT(COUNTER_HALT), .COUNTER_CLEAR(COUNTER_CLEAR),
    .MODULO_VALUE(MODULO_VALUE), .COUNT_VALUE(COUNT_VALUE), .OVERFLOW(OVERFLOW),
    .CHAN_PIN_IN(CHAN_PIN_IN), .CHAN_PIN_OUT(CHAN_PIN_OUT), .CHAN_PIN_OE(CHAN_PIN_OE),
    .CHAN_IRQ(CHAN_IRQ));
  tcc_pin_model tcc_pin_model_i (.clk(SYS_CLK), .lvl(lvl), .oe(CHAN_PIN_OE),
    .out(CHAN_PIN_OUT), .pin(CHAN_PIN_IN));
  // counter model
  always @(posedge SYS_CLK)
  begin
    if (RST || CE)
      o <= !RST && !COUNTER_CLEAR && COUNT_TICK && !COUNTER_HALT && m == MODULO_VALUE;
    if (RST || (CE && COUNTER_CLEAR))
      m <= 0;
    else if (CE && COUNT_TICK && !COUNTER_HALT)
      m <= (m == MODULO_VALUE) ? 0 : m + 1;
  end
  always @(negedge SYS_CLK)
  begin
    `CK("count", m[15:0], COUNT_VALUE)
    `CK("ovf", o, OVERFLOW)
  end
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task end_sim();
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    q = PRDATA[7:0];
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    if (PREADY !== 1'b1)
    begin
      fail_count++;
      end_sim();
    end
    @(negedge SYS_CLK);
  endtask
  task automatic wt();
    int n;
    n = 0;
    while (CHAN_IRQ[0] !== 1'b1 && n < 600)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    if (CHAN_IRQ[0] !== 1'b1)
    begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic clr(input logic [7:0] a, input logic [7:0] v);
    apb(0, a, 8'h00);
    apb(1, a, v);
  endtask
  task automatic edg(input logic v);
    @(posedge SYS_CLK);
    lvl[1] <= v;
    repeat (6) @(negedge SYS_CLK);
  endtask
  initial
  begin
    repeat (3) @(posedge SYS_CLK);
    RST <= 0;
    apb(0, 8'h58, 8'h00);
    `CK("ctrl0", 8'h00, q)
    apb(0, 8'h64, 8'h00);
    `CK("ctrl1", 8'h00, q)
    `CK("oe", 2'b00, CHAN_PIN_OE)
    `CK("irq", 2'b00, CHAN_IRQ)
    `CK("preset", 1'b1, CHAN_PIN_OUT[0])
    apb(0, 8'h70, 8'h00);
    `CK("unmapped", 1'b1, e)
    for (k = 1; k < 4; k++)
    begin
      c = 8'h50 | (k[7:0] << 2);
      @(posedge SYS_CLK);
      COUNTER_HALT <= 1;
      COUNTER_CLEAR <= 1;
      apb(1, 8'h58, c);
      r = 16'h0008 + (xs() & 16'h003f);
      apb(1, 8'h5c, r[15:8]);
      apb(1, 8'h60, r[7:0]);
      p = CHAN_PIN_OUT[0];
      @(posedge SYS_CLK);
      COUNTER_HALT <= 0;
      COUNTER_CLEAR <= 0;
      wt();
      `CK("match", r + 16'h0001, COUNT_VALUE)
      `CK("pin", (k == 1) ? ~p : k[0], CHAN_PIN_OUT[0])
      `CK("oe0", 1'b1, CHAN_PIN_OE[0])
      @(posedge SYS_CLK);
      COUNTER_HALT <= 1;
      apb(1, 8'h58, c);
      `CK("blind", 1'b1, CHAN_IRQ[0])
      clr(8'h58, c);
      `CK("clear", 1'b0, CHAN_IRQ[0])
      apb(1, 8'h58, c | 8'h80);
      apb(0, 8'h58, 8'h00);
      `CK("set1", c, q)
    end
    for (k = 1; k < 4; k++)
    begin
      c = 8'h40 | (k[7:0] << 2);
      apb(1, 8'h64, c);
      @(posedge SYS_CLK);
      COUNTER_HALT <= 0;
      repeat (1 + (xs() & 7)) @(posedge SYS_CLK);
      COUNTER_HALT <= 1;
      edg(1'b1);
      `CK("rise", k != 2, CHAN_IRQ[1])
      apb(0, 8'h68, 8'h00);
      h = q;
      apb(0, 8'h6c, 8'h00);
      if (k != 2)
        `CK("capture", m[15:0], {h, q})
      clr(8'h64, c);
      edg(1'b0);
      `CK("fall", k != 1, CHAN_IRQ[1])
      clr(8'h64, c);
    end
    apb(0, 8'h68, 8'h00);
    edg(1'b1);
    `CK("inhibit", 1'b0, CHAN_IRQ[1])
    apb(0, 8'h6c, 8'h00);
    edg(1'b0);
    `CK("resume", 1'b1, CHAN_IRQ[1])
    apb(1, 8'h64, 8'h14);
    apb(1, 8'h58, 8'h24);
    repeat (2) @(negedge SYS_CLK);
    `CK("oe1", 1'b0, CHAN_PIN_OE[1])
    apb(1, 8'h64, 8'h18);
    apb(1, 8'h58, 8'h00);
    apb(0, 8'h64, 8'h00);
    `CK("ctrl1", 8'h14, q & 8'h7f)
    `CK("oe0", 1'b0, CHAN_PIN_OE[0])
    // overflow toggle against a same-cycle set on compare
    @(posedge SYS_CLK);
    COUNTER_HALT <= 1;
    COUNTER_CLEAR <= 1;
    MODULO_VALUE <= 16'h0020;
    apb(1, 8'h58, 8'h5e);
    apb(1, 8'h5c, 8'h00);
    apb(1, 8'h60, 8'h00);
    @(posedge SYS_CLK);
    COUNTER_HALT <= 0;
    COUNTER_CLEAR <= 0;
    repeat (3) @(posedge SYS_CLK);
    CE <= 0;
    repeat (4) @(negedge SYS_CLK);
    `CK("ready", 1'b0, PREADY)
    @(posedge SYS_CLK);
    CE <= 1;
    wt();
    `CK("tov", 1'b0, CHAN_PIN_OUT[0])
    clr(8'h58, 8'h5e);
    wt();
    `CK("tov2", 1'b1, CHAN_PIN_OUT[0])
    // full duty from the next period on
    @(posedge SYS_CLK);
    COUNTER_HALT <= 1;
    COUNTER_CLEAR <= 1;
    clr(8'h58, 8'h59);
    apb(1, 8'h5c, 8'h00);
    apb(1, 8'h60, 8'h08);
    @(posedge SYS_CLK);
    COUNTER_HALT <= 0;
    COUNTER_CLEAR <= 0;
    wt();
    `CK("duty", 1'b0, CHAN_PIN_OUT[0])
    clr(8'h58, 8'h59);
    wt();
    `CK("duty2", 1'b1, CHAN_PIN_OUT[0])
    // buffered compare swaps to channel 1 values at overflow
    @(posedge SYS_CLK);
    COUNTER_HALT <= 1;
    COUNTER_CLEAR <= 1;
    clr(8'h58, 8'h64);
    apb(1, 8'h5c, 8'h00);
    apb(1, 8'h60, 8'h04);
    apb(1, 8'h68, 8'h00);
    apb(1, 8'h6c, 8'h10);
    @(posedge SYS_CLK);
    COUNTER_HALT <= 0;
    COUNTER_CLEAR <= 0;
    wt();
    `CK("buf0", 16'h0005, COUNT_VALUE)
    clr(8'h58, 8'h64);
    wt();
    `CK("buf1", 16'h0011, COUNT_VALUE)
    // preset low while disconnected
    apb(1, 8'h58, 8'h10);
    @(negedge SYS_CLK);
    `CK("preset_low", 1'b0, CHAN_PIN_OUT[0])
    `CK("port0", 1'b0, CHAN_PIN_OE[0])
    end_sim();
  end
endmodule
